// file: rtl/epo_pkg.sv
// Package with constants and types for the energy pulse output block
package epo_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 250_000_000;
  localparam int PULSE_ON_S = 1;
  localparam int PULSE_OFF_S = 1;
  localparam int PULSE_ON_CYC = CLK_HZ * PULSE_ON_S;
  localparam int PULSE_OFF_CYC = CLK_HZ * PULSE_OFF_S;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_CH = 4;
  localparam int NUM_RLY = 5;
  localparam int IVL_W = 16;
  localparam int PEND_W = 8;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_CFG0 = 12'h010;
  localparam logic [11:0] OFS_PROG0 = 12'h020;
  localparam logic [11:0] OFS_PEND0 = 12'h030;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CFG_RLY_LSB = 16;
  localparam int STS_ON_LSB = 0;
  localparam int STS_PEND_LSB = 4;
  localparam int STS_EVT_LSB = 8;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] IVL_RST = 16'h0064;
  localparam logic [4:0] RLY_RST = 5'h00;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    EPO_FN_DISABLED,
    EPO_FN_ALARM,
    EPO_FN_LATCHED,
    EPO_FN_CONTROL
  } epo_func_type;

  typedef enum logic [1:0] {
    EPO_SEQ_IDLE,
    EPO_SEQ_ON,
    EPO_SEQ_OFF
  } epo_seq_type;

endpackage : epo_pkg

// file: rtl/epo_accum.sv
// Per-channel energy progress counter toward the next interval boundary
`timescale 1ns/10ps
module epo_accum #(
  parameter int IVL_W = epo_pkg::IVL_W
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic step,
  input wire logic [IVL_W-1:0] interval,
  input wire logic load,
  input wire logic [IVL_W-1:0] load_val,
  output logic [IVL_W-1:0] progress,
  output logic done
);

  typedef struct packed {
    logic [IVL_W-1:0] progress;
    logic done;
  } epo_acc_state_type;

  epo_acc_state_type s_r;
  epo_acc_state_type s_nxt;

  always_comb begin
    logic [IVL_W:0] inc;
    inc = {1'b0, s_r.progress} + {{IVL_W{1'b0}}, 1'b1};
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (load) begin
      // Restore of saved progress after power up
      s_nxt.progress = load_val;
    end else if (step && (interval != '0)) begin
      if (inc >= {1'b0, interval}) begin
        s_nxt.progress = '0;
        s_nxt.done = 1'b1;
      end else begin
        s_nxt.progress = inc[IVL_W-1:0];
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign progress = s_r.progress;
  assign done = s_r.done;

endmodule : epo_accum

// file: rtl/epo_pulse.sv
// Per-channel pulse sequencer: pending count, one second on, one second off
`timescale 1ns/10ps
module epo_pulse #(
  parameter int ON_CYC = epo_pkg::PULSE_ON_CYC,
  parameter int OFF_CYC = epo_pkg::PULSE_OFF_CYC,
  parameter int PEND_W = epo_pkg::PEND_W
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic enable,
  input wire logic request,
  output logic energized,
  output logic [PEND_W-1:0] pending
);

  localparam int TW = $clog2((ON_CYC > OFF_CYC ? ON_CYC : OFF_CYC) + 1);
  localparam logic [TW-1:0] ON_LAST = TW'(ON_CYC - 1);
  localparam logic [TW-1:0] OFF_LAST = TW'(OFF_CYC - 1);

  typedef struct packed {
    epo_pkg::epo_seq_type st;
    logic [TW-1:0] tmr;
    logic [PEND_W-1:0] pend;
    logic on;
  } epo_seq_state_type;

  epo_seq_state_type s_r;
  epo_seq_state_type s_nxt;

  always_comb begin
    s_nxt = s_r;
    // Extra completions wait here and drain at the maximum rate
    if (request && !(&s_r.pend)) begin
      s_nxt.pend = s_r.pend + {{(PEND_W-1){1'b0}}, 1'b1};
    end
    unique case (s_r.st)
      epo_pkg::EPO_SEQ_IDLE: begin
        if (s_nxt.pend != '0) begin
          s_nxt.pend = s_nxt.pend - {{(PEND_W-1){1'b0}}, 1'b1};
          s_nxt.st = epo_pkg::EPO_SEQ_ON;
          s_nxt.tmr = '0;
          s_nxt.on = 1'b1;
        end
      end
      epo_pkg::EPO_SEQ_ON: begin
        if (s_r.tmr == ON_LAST) begin
          s_nxt.st = epo_pkg::EPO_SEQ_OFF;
          s_nxt.tmr = '0;
          s_nxt.on = 1'b0;
        end else begin
          s_nxt.tmr = s_r.tmr + {{(TW-1){1'b0}}, 1'b1};
        end
      end
      epo_pkg::EPO_SEQ_OFF: begin
        if (s_r.tmr == OFF_LAST) begin
          s_nxt.st = epo_pkg::EPO_SEQ_IDLE;
          s_nxt.tmr = '0;
        end else begin
          s_nxt.tmr = s_r.tmr + {{(TW-1){1'b0}}, 1'b1};
        end
      end
      default: begin
        s_nxt.st = epo_pkg::EPO_SEQ_IDLE;
        s_nxt.on = 1'b0;
      end
    endcase
    if (!enable) begin
      s_nxt = '0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign energized = s_r.on;
  assign pending = s_r.pend;

endmodule : epo_pulse

// file: rtl/epo_top.sv
// Energy pulse output block with its AHB-Lite register slave
//
// Operation
// - Function select, disabled after reset
// - Four channels, own relays and interval
// - Channel drives relays 3-7 together
// - Interval 0.0 to 6553.5, default 10.0
// - One pulse request per completed interval
// - Progress kept and restorable across power loss
// - One second on, one second off
// - Excess requests queued, emitted at max rate
//
// The AHB-Lite register port and the address map were decided locally.
`timescale 1ns/10ps
module epo_top #(
  parameter int ON_CYC = epo_pkg::PULSE_ON_CYC,
  parameter int OFF_CYC = epo_pkg::PULSE_OFF_CYC,
  parameter int PEND_W = epo_pkg::PEND_W
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [3:0] energy_step,
  output logic [4:0] relay_out
);

  localparam int NCH = epo_pkg::NUM_CH;
  localparam int NR = epo_pkg::NUM_RLY;
  localparam int IW = epo_pkg::IVL_W;

  // ****************************************
  // Address decode helper
  // ****************************************
  // Returns channel hit mask for a 4-word channel group at base
  function automatic logic [3:0] epo_ch_hit(input logic [11:0] addr, input logic [11:0] base);
    logic [3:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      if (addr == base + 12'(4 * i)) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction : epo_ch_hit

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic wr_pend;
    logic [11:0] wr_addr;
    epo_pkg::epo_func_type func;
    logic [NCH-1:0][NR-1:0] rly;
    logic [NCH-1:0][IW-1:0] ivl;
    logic [NCH-1:0] evt;
    logic [NR-1:0] relay;
    logic [31:0] rdata;
  } epo_top_state_type;

  epo_top_state_type s_r;
  epo_top_state_type s_nxt;

  logic [NCH-1:0] done;
  logic [NCH-1:0] on;
  logic [NCH-1:0] load;
  logic [NCH-1:0][IW-1:0] prog;
  logic [NCH-1:0][PEND_W-1:0] pend;
  logic enable;
  logic addr_ph;
  logic [11:0] ra;

  assign enable = (s_r.func != epo_pkg::EPO_FN_DISABLED);
  assign addr_ph = hsel && hready && htrans[1];
  assign ra = haddr[11:0];
  assign load = s_r.wr_pend ? epo_ch_hit(s_r.wr_addr, epo_pkg::OFS_PROG0) : '0;

  // ****************************************
  // Channels
  // ****************************************
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    epo_accum #(
      .IVL_W(IW)
    ) u_accum (
      .mclk(mclk),
      .rst(rst),
      .step(energy_step[c]),
      .interval(s_r.ivl[c]),
      .load(load[c]),
      .load_val(hwdata[IW-1:0]),
      .progress(prog[c]),
      .done(done[c])
    );

    epo_pulse #(
      .ON_CYC(ON_CYC),
      .OFF_CYC(OFF_CYC),
      .PEND_W(PEND_W)
    ) u_pulse (
      .mclk(mclk),
      .rst(rst),
      .enable(enable),
      .request(done[c]),
      .energized(on[c]),
      .pending(pend[c])
    );
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [NR-1:0] rmix;
    logic [3:0] hit;
    logic [31:0] rd;
    logic [NCH-1:0] pend_nz;
    rmix = '0;
    hit = '0;
    rd = '0;
    pend_nz = '0;
    s_nxt = s_r;

    // Relay drive, all selected relays of a channel at once
    for (int c = 0; c < NCH; c++) begin
      if (on[c]) begin
        rmix = rmix | s_r.rly[c];
      end
      pend_nz[c] = (pend[c] != '0);
    end
    s_nxt.relay = enable ? rmix : '0;

    // Data phase of a write
    s_nxt.wr_pend = 1'b0;
    if (s_r.wr_pend) begin
      if (s_r.wr_addr == epo_pkg::OFS_CTRL) begin
        s_nxt.func = epo_pkg::epo_func_type'(hwdata[1:0]);
      end
      if (s_r.wr_addr == epo_pkg::OFS_STATUS) begin
        s_nxt.evt = s_r.evt & ~hwdata[epo_pkg::STS_EVT_LSB +: NCH];
      end
      hit = epo_ch_hit(s_r.wr_addr, epo_pkg::OFS_CFG0);
      for (int c = 0; c < NCH; c++) begin
        if (hit[c]) begin
          s_nxt.ivl[c] = hwdata[IW-1:0];
          s_nxt.rly[c] = hwdata[epo_pkg::CFG_RLY_LSB +: NR];
        end
      end
    end

    // Latched event flags, set wins over clear
    for (int c = 0; c < NCH; c++) begin
      if (done[c] && s_r.func == epo_pkg::EPO_FN_LATCHED) begin
        s_nxt.evt[c] = 1'b1;
      end
    end
    if (!enable) begin
      s_nxt.evt = '0;
    end

    // Address phase
    if (addr_ph) begin
      s_nxt.wr_pend = hwrite;
      s_nxt.wr_addr = ra;
      if (!hwrite) begin
        if (ra == epo_pkg::OFS_CTRL) begin
          rd = {30'h0, s_r.func};
        end
        if (ra == epo_pkg::OFS_STATUS) begin
          rd[epo_pkg::STS_ON_LSB +: NCH] = on;
          rd[epo_pkg::STS_PEND_LSB +: NCH] = pend_nz;
          rd[epo_pkg::STS_EVT_LSB +: NCH] = s_r.evt;
        end
        for (int c = 0; c < NCH; c++) begin
          if (epo_ch_hit(ra, epo_pkg::OFS_CFG0) == 4'(1 << c)) begin
            rd[IW-1:0] = s_r.ivl[c];
            rd[epo_pkg::CFG_RLY_LSB +: NR] = s_r.rly[c];
          end
          if (epo_ch_hit(ra, epo_pkg::OFS_PROG0) == 4'(1 << c)) begin
            rd[IW-1:0] = prog[c];
          end
          if (epo_ch_hit(ra, epo_pkg::OFS_PEND0) == 4'(1 << c)) begin
            rd[PEND_W-1:0] = pend[c];
          end
        end
        s_nxt.rdata = rd;
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_r.wr_pend <= 1'b0;
      s_r.wr_addr <= 12'h000;
      s_r.func <= epo_pkg::EPO_FN_DISABLED;
      for (int c = 0; c < NCH; c++) begin
        s_r.rly[c] <= epo_pkg::RLY_RST;
        s_r.ivl[c] <= epo_pkg::IVL_RST;
      end
      s_r.evt <= '0;
      s_r.relay <= '0;
      s_r.rdata <= 32'h0000_0000;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_r.rdata;
  assign relay_out = s_r.relay;

endmodule : epo_top

// file: sim/epo_checker.sv
// Port assertions for the energy pulse output block
`timescale 1ns/10ps
module epo_checker #(
  parameter int ON_CYC = 8,
  parameter int OFF_CYC = 8,
  parameter int PEND_W = 8
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [4:0] relay_out
);
  // ****
  // Function tracking
  // ****
  logic wr_r;
  logic [1:0] fn_r;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_r <= 1'b0;
      fn_r <= 2'h0;
    end else begin
      wr_r <= hsel && hready && htrans[1] && hwrite && haddr[11:0] == 12'h000;
      if (wr_r) begin
        fn_r <= hwdata[1:0];
      end
    end
  end
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence s_on;
    relay_out[0] [*8];
  endsequence
  sequence s_off;
    !relay_out[4] [*8];
  endsequence
  a_reset_quiet: assert property ($fell(rst) |-> relay_out == 5'h00 && hrdata == 32'h0)
    else $error("outputs not idle after reset");
  a_disabled_quiet: assert property ((fn_r == 2'h0) [*3] |-> relay_out == 5'h00)
    else $error("relay active while disabled");
  a_rise_enabled: assert property ($rose(|relay_out) |-> fn_r != 2'h0)
    else $error("relay rose while disabled");
  a_on_time: assert property ($rose(relay_out[0]) |-> s_on ##1 !relay_out[0])
    else $error("relay on time wrong");
  a_off_time: assert property ($fell(relay_out[4]) |-> s_off)
    else $error("relay off time too short");
  a_pulse_gap: assert property ($rose(relay_out[4]) |=> (!$rose(relay_out[4])) [*8])
    else $error("pulses too close");
  a_bus_ready: assert property (hreadyout)
    else $error("slave not ready");
  a_bus_okay: assert property (!hresp)
    else $error("slave response not okay");
endmodule : epo_checker

bind epo_top epo_checker #(.ON_CYC(ON_CYC), .OFF_CYC(OFF_CYC), .PEND_W(PEND_W)) chk_u (
  .mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp,
  .hrdata, .relay_out);

// file: sim/epo_equipment.sv
// Model of equipment wired to the auxiliary relays
`timescale 1ns/10ps
module epo_equipment (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [4:0] relay_out,
  output logic [7:0] cnt [5]
);
  logic [4:0] prev_r;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prev_r <= 5'h00;
      for (int i = 0; i < 5; i++) begin
        cnt[i] <= 8'h00;
      end
    end else begin
      prev_r <= relay_out;
      for (int i = 0; i < 5; i++) begin
        if (prev_r[i] && !relay_out[i]) begin
          cnt[i] <= cnt[i] + 8'h01;
        end
      end
    end
  end
endmodule : epo_equipment

// file: sim/testbench.sv
// Self-checking bench for the energy pulse output block
`timescale 1ns/10ps
module testbench;
  logic mclk, rst, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] energy_step;
  logic [4:0] relay_out;
  logic [7:0] cnt [5];
  int err_total, checked;
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  epo_top #(.ON_CYC(8), .OFF_CYC(8), .PEND_W(8)) dut_u (.mclk, .rst, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .energy_step,
    .relay_out);
  epo_equipment eq_u (.mclk, .rst, .relay_out, .cnt);
  // ****
  // Shared tasks
  // ****
  task results;
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task hwait;
    int n;
    n = 0;
    @(posedge mclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        err_total++;
        results();
      end
      @(posedge mclk);
    end
  endtask : hwait
  task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hwait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hwait();
    q = hrdata;
  endtask : ahb
  task rd(input logic [11:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    cmp(q, e);
  endtask : rd
  task steps(input logic [3:0] m, input int n);
    repeat (n) begin
      energy_step <= m;
      @(posedge mclk);
    end
    energy_step <= 4'h0;
  endtask : steps
  task wrly(input int b);
    int n;
    n = 0;
    while (relay_out[b] !== 1'b1) begin
      @(posedge mclk);
      n++;
      if (n > 20) begin
        err_total++;
        results();
      end
    end
  endtask : wrly
  // ****
  // Scenarios
  // ****
  task t_defaults;
    rd(12'h000, 32'h0);
    rd(12'h010, 32'h64);
    rd(12'h020, 32'h0);
    rd(12'hffc, 32'h0);
    for (int i = 3; i >= 0; i--) begin
      ahb(1'b1, 12'h000, 32'(i));
      rd(12'h000, 32'(i));
    end
    ahb(1'b1, 12'h010, 32'h0003ffff);
    rd(12'h010, 32'h0003ffff);
    $display("t_defaults done");
  endtask : t_defaults
  task t_disabled;
    ahb(1'b1, 12'h010, 32'h00030002);
    steps(4'h1, 4);
    repeat (20) @(posedge mclk);
    cmp(relay_out, 32'h0);
    cmp(cnt[0], 32'h0);
    $display("t_disabled done");
  endtask : t_disabled
  task t_restore;
    ahb(1'b1, 12'h020, 32'h1);
    ahb(1'b1, 12'h000, 32'h1);
    steps(4'h1, 1);
    wrly(0);
    cmp(relay_out, 32'h03);
    steps(4'h1, 1);
    repeat (30) @(posedge mclk);
    cmp(cnt[0], 32'h1);
    cmp(cnt[1], 32'h1);
    $display("t_restore done");
  endtask : t_restore
  task t_queue;
    ahb(1'b1, 12'h014, 32'h00100001);
    ahb(1'b1, 12'h018, 32'h00040000);
    ahb(1'b1, 12'h01c, 32'h00080003);
    steps(4'he, 3);
    ahb(1'b0, 12'h034, 32'h0);
    cmp(q != 32'h0, 32'h1);
    repeat (60) @(posedge mclk);
    cmp(cnt[4], 32'h3);
    cmp(cnt[2], 32'h0);
    cmp(cnt[3], 32'h1);
    $display("t_queue done");
  endtask : t_queue
  task t_disable_mid;
    steps(4'h8, 3);
    wrly(3);
    ahb(1'b1, 12'h000, 32'h0);
    repeat (2) @(posedge mclk);
    cmp(relay_out, 32'h0);
    rd(12'h03c, 32'h0);
    $display("t_disable_mid done");
  endtask : t_disable_mid
  task t_latched;
    ahb(1'b1, 12'h000, 32'h2);
    steps(4'h1, 1);
    repeat (20) @(posedge mclk);
    rd(12'h004, 32'h100);
    cmp(cnt[0], 32'h2);
    ahb(1'b1, 12'h004, 32'h100);
    rd(12'h004, 32'h0);
    rd(12'h020, 32'h0);
    $display("t_latched done");
  endtask : t_latched
  initial begin
    err_total = 0;
    checked = 0;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    energy_step = 4'h0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    t_defaults();
    t_disabled();
    t_restore();
    t_queue();
    t_disable_mid();
    t_latched();
    results();
  end
endmodule : testbench
